/* File: rtl/txos_consts.svh */
`ifndef TXOS_CONSTS_SVH
`define TXOS_CONSTS_SVH

// ==========================================================
// Oversampled transmit path constants
`define TXOS_OSR           5
`define TXOS_OSR_LAST      3'h4
`define TXOS_PHASE_RST     3'h0
`define TXOS_FIFO_DEPTH    8
`define TXOS_CHANNELS      4
`define TXOS_SYMBOLS       2
`define TXOS_BITS_PER_SYM  10

`endif

/* File: rtl/txos_pkg.sv */
`include "txos_consts.svh"

package txos_pkg;

   // ==========================================================
   // Path modes, one-hot
   typedef enum logic [2:0] {
      TXOS_IDLE   = 3'h1,
      TXOS_BYPASS = 3'h2,
      TXOS_OVER   = 3'h4
   } txos_mode_type;

   // ==========================================================
   // Transceiver status seen by the path
   typedef struct packed {
      logic [`TXOS_CHANNELS-1:0] calBusy;
      logic [`TXOS_CHANNELS-1:0] digitalReset;
      logic                      pllLocked;
   } txos_xcvr_status_type;

endpackage

/* File: rtl/txos_oversampler.sv */
// Overview of operation
// - Repeat every input bit five times in sequence
// - Input word taken once per five cycles when oversampling, every cycle in bypass
// - Oversample only below minimum rate, one read
// - Enable pulse every fifth cycle reads FIFO
// - Parallel bus is S times 4 times 10
// - Calibration busy high during calibration or reset
// - PLL power-down resets PLL; lock rises later

`include "txos_consts.svh"

// ==========================================================
// Word FIFO with registered flags
module txos_fifo #(
   parameter int WIDTH = 80,
   parameter int DEPTH = `TXOS_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   // Fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   // Count at DEPTH marks a full buffer
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wrPtr_q;
   logic [AW-1:0]    wrPtr_d;
   logic [AW-1:0]    rdPtr_q;
   logic [AW-1:0]    rdPtr_d;
   logic [AW:0]      count_q;
   logic [AW:0]      count_d;
   logic             notFull_q;
   logic             notFull_d;
   logic             notEmpty_q;
   logic             notEmpty_d;
   logic             push;
   logic             pop;

   assign inReady  = notFull_q;
   assign outValid = notEmpty_q;
   assign outData  = mem_q[rdPtr_q];
   assign push     = inValid & notFull_q;
   assign pop      = outReady & notEmpty_q;

   // Pointer and flag next values
   always_comb begin
      wrPtr_d = wrPtr_q;
      rdPtr_d = rdPtr_q;
      count_d = count_q;
      if (push) begin
         wrPtr_d = (wrPtr_q == LAST_PTR) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
         rdPtr_d = (rdPtr_q == LAST_PTR) ? '0 : rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
         count_d = count_q + 1'b1;
      end else if (pop && !push) begin
         count_d = count_q - 1'b1;
      end
      notFull_d  = (count_d != FULL_CNT);
      notEmpty_d = (count_d != '0);
   end

   // Pointer and flag registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wrPtr_q    <= '0;
         rdPtr_q    <= '0;
         count_q    <= '0;
         notFull_q  <= 1'b0; // Ready from the first edge after reset
         notEmpty_q <= 1'b0;
      end else begin
         wrPtr_q    <= wrPtr_d;
         rdPtr_q    <= rdPtr_d;
         count_q    <= count_d;
         notFull_q  <= notFull_d;
         notEmpty_q <= notEmpty_d;
      end
   end

   // Storage, written only on accepted words
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wrPtr_q] <= inData;
      end
   end
endmodule // txos_fifo

// ==========================================================
// Clock enable generator, one pulse every RATIO cycles
module txos_clk_en_gen #(
   parameter int RATIO = `TXOS_OSR
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // Run control and enable pulse
   input  wire logic run,
   output logic      enable
);
   // Phase counter width and wrap point
   localparam int            CW   = (RATIO > 1) ? $clog2(RATIO) : 1;
   localparam logic [CW-1:0] LAST = CW'(RATIO - 1);

   logic [CW-1:0] phase_q;
   logic [CW-1:0] phase_d;

   // Pulse on the last phase of each group, only while running
   assign enable = run & (phase_q == LAST);

   // Phase next value, restarts from zero whenever the path stops
   always_comb begin
      phase_d = '0;
      if (run) begin
         phase_d = (phase_q == LAST) ? '0 : phase_q + 1'b1;
      end
   end

   // Phase register
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         phase_q <= '0;
      end else begin
         phase_q <= phase_d;
      end
   end
endmodule // txos_clk_en_gen

// ==========================================================
// Low-rate transmit oversampler
module txos_oversampler
   import txos_pkg::*;
#(
   parameter int SYMBOLS    = `TXOS_SYMBOLS,
   parameter int FIFO_DEPTH = `TXOS_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst_b,
   // Mode control
   input  wire logic                 lowRate,
   // Transceiver status
   input  wire txos_xcvr_status_type xcvrStatus,
   // Word source
   input  wire logic                 srcValid,
   output logic                      srcReady,
   input  wire logic [SYMBOLS*`TXOS_CHANNELS*`TXOS_BITS_PER_SYM-1:0] srcData,
   // Transceiver parallel data
   output logic [SYMBOLS*`TXOS_CHANNELS*`TXOS_BITS_PER_SYM-1:0]      txParallelData_q,
   output logic                      txDataValid_q,
   output logic                      readStrobe_q,
   output logic                      underrun_q
);
   localparam int OUT_W = SYMBOLS * `TXOS_CHANNELS * `TXOS_BITS_PER_SYM;
   localparam int CHUNK = OUT_W / `TXOS_OSR;

   logic             fifoReady;
   logic             fifoValid;
   logic             fifoPop;
   logic [OUT_W-1:0] fifoData;
   logic             linkUp;
   txos_mode_type    mode_q;
   txos_mode_type    mode_d;
   logic [2:0]       chunk_q;
   logic [2:0]       chunk_d;
   logic [OUT_W-1:0] word_q;
   logic [OUT_W-1:0] word_d;
   logic [OUT_W-1:0] txParallelData_d;
   logic             txDataValid_d;
   logic             readStrobe_d;
   logic             underrun_d;
   logic             strobe;

   // Buffer between the word source and the transceiver
   txos_fifo #(
      .WIDTH (OUT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .inValid  (srcValid),
      .inReady  (fifoReady),
      .inData   (srcData),
      .outValid (fifoValid),
      .outReady (fifoPop),
      .outData  (fifoData)
   );

   // Ready is the buffer's registered not-full flag, so every handshake lands
   assign srcReady = fifoReady;

   // Link usable only when every channel is calibrated and out of reset
   assign linkUp = xcvrStatus.pllLocked
                 & ~|xcvrStatus.calBusy
                 & ~|xcvrStatus.digitalReset;

   // Read strobe generator, runs only in the oversampled mode
   txos_clk_en_gen #(
      .RATIO (`TXOS_OSR)
   ) u_clk_en (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .run     (mode_q == TXOS_OVER),
      .enable  (strobe)
   );

   // Read every cycle in bypass, once per group when oversampling
   assign fifoPop = (mode_q == TXOS_BYPASS) | strobe;

   // Mode, chunk and word next values
   // Group phase is kept by the enable generator
   always_comb begin
      mode_d  = TXOS_IDLE;
      chunk_d = chunk_q;
      word_d  = word_q;
      if (linkUp) begin
         mode_d = lowRate ? TXOS_OVER : TXOS_BYPASS;
      end
      case (mode_q)
         TXOS_OVER: begin
            // Input taken only on the strobe, ignored on the other four
            if (strobe) begin
               word_d  = fifoValid ? fifoData : '0;
               chunk_d = `TXOS_PHASE_RST;
            end else if (chunk_q != `TXOS_OSR_LAST) begin
               chunk_d = chunk_q + 3'h1;
            end
         end
         default: begin
            chunk_d = `TXOS_OSR_LAST;
            word_d  = '0;
         end
      endcase
   end

   // Mode, chunk and word registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mode_q  <= TXOS_IDLE;
         chunk_q <= `TXOS_OSR_LAST;
         word_q  <= '0;
      end else begin
         mode_q  <= mode_d;
         chunk_q <= chunk_d;
         word_q  <= word_d;
      end
   end

   // Output word: each bit of the current chunk repeated, low bit first
   always_comb begin
      int idx;
      idx              = 0;
      txParallelData_d = '0;
      txDataValid_d    = 1'b0;
      readStrobe_d     = strobe;
      // Underrun only when a strobe finds the buffer empty
      underrun_d       = strobe & ~fifoValid;
      case (mode_q)
         TXOS_OVER: begin
            for (int i = 0; i < OUT_W; i++) begin
               idx = int'(chunk_q) * CHUNK + i / `TXOS_OSR;
               txParallelData_d[i] = word_q[idx];
            end
            txDataValid_d = 1'b1;
         end
         TXOS_BYPASS: begin
            txParallelData_d = fifoValid ? fifoData : '0;
            txDataValid_d    = fifoValid;
         end
         default: begin
            txParallelData_d = '0;
            underrun_d       = 1'b0;
         end
      endcase
   end

   // Output registers, clocked by the channel zero parallel clock
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         txParallelData_q <= '0;
         txDataValid_q    <= 1'b0;
         readStrobe_q     <= 1'b0;
         underrun_q       <= 1'b0;
      end else begin
         txParallelData_q <= txParallelData_d;
         txDataValid_q    <= txDataValid_d;
         readStrobe_q     <= readStrobe_d;
         underrun_q       <= underrun_d;
      end
   end
endmodule // txos_oversampler

/* File: tb/txos_xcvr_model.sv */
// ====================
// Transceiver and reset controller model
module txos_xcvr_model
   import txos_pkg::*;
#(
   parameter int LOCK_CYC = 12,
   parameter int CAL_CYC  = 20
) (
   // Clock and reset, reset also powers the PLL down
   input  wire logic           clk_sys,
   input  wire logic           rst_b,
   // Reconfiguration controller held in reset
   input  wire logic           calHold,
   // Status toward the path
   output txos_xcvr_status_type xcvrStatus
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;

   // Bring-up timer restarted by every reset
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) cnt <= 0;
      else if (cnt < CAL_CYC + 2) cnt <= cnt + 1;
   end

   // Lock arrives late, resets leave after lock and calibration
   always_comb begin
      xcvrStatus.pllLocked    = (cnt >= LOCK_CYC);
      xcvrStatus.calBusy      = {4{cnt < CAL_CYC || calHold}};
      xcvrStatus.digitalReset = {4{cnt < CAL_CYC + 2 || cnt < LOCK_CYC}};
   end
endmodule // txos_xcvr_model

/* File: tb/txos_oversampler_assertions.sv */
`include "txos_consts.svh"

// ====================
// Port checker
module txos_oversampler_checker
   import txos_pkg::*;
#(
   parameter int SYMBOLS = `TXOS_SYMBOLS,
   parameter int W       = SYMBOLS*`TXOS_CHANNELS*`TXOS_BITS_PER_SYM
) (
   // Clock and reset
   input wire logic                 clk_sys,
   input wire logic                 rst_b,
   // Mode and status
   input wire logic                 lowRate,
   input wire txos_xcvr_status_type xcvrStatus,
   // Transceiver side
   input wire logic [W-1:0]         txParallelData_q,
   input wire logic                 txDataValid_q,
   input wire logic                 readStrobe_q,
   input wire logic                 underrun_q
);
   timeunit 1ns;
   timeprecision 1ns;
   wire linkUp = xcvrStatus.pllLocked && xcvrStatus.calBusy == 0 && xcvrStatus.digitalReset == 0;
   wire okLow  = linkUp && lowRate;

   // True when every bit group holds five equal copies
   function automatic logic fiveCopies(logic [W-1:0] d);
      for (int g = 0; g < W / 5; g++) if (d[5*g+:5] != {5{d[5*g]}}) return 1'b0;
      return 1'b1;
   endfunction

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   // Strobe seen with the oversampled mode held around it
   sequence sStrobeRun;
      okLow ##1 (readStrobe_q && okLow) ##1 okLow[*3];
   endsequence

   a_strobe_gap: assert property (
      sStrobeRun |-> !readStrobe_q && !$past(readStrobe_q) && !$past(readStrobe_q, 2))
      else $error("strobe came early");
   a_strobe_period: assert property (sStrobeRun |=> !readStrobe_q ##1 readStrobe_q)
      else $error("strobe period wrong");
   a_first_read: assert property ($rose(okLow) ##1 okLow[*4] |=> ##1 readStrobe_q)
      else $error("first read late");
   a_copies_five: assert property (okLow[*3] |-> fiveCopies(txParallelData_q))
      else $error("bit copies differ");
   a_valid_over: assert property (okLow[*3] |-> txDataValid_q)
      else $error("valid dropped");
   a_idle_quiet: assert property (
      (!linkUp)[*3] |-> !txDataValid_q && !readStrobe_q && txParallelData_q == '0)
      else $error("output while link down");
   a_gated_read: assert property (readStrobe_q |-> $past(linkUp, 2))
      else $error("read without link");
   a_underrun_read: assert property (underrun_q |-> readStrobe_q || $past(readStrobe_q))
      else $error("underrun without read");
endmodule // txos_oversampler_checker

/* File: tb/tb_txos_oversampler.sv */
`include "txos_consts.svh"

// ====================
// Bench top
module tb_txos_oversampler
   import txos_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int W = `TXOS_SYMBOLS*`TXOS_CHANNELS*`TXOS_BITS_PER_SYM;
   logic                 clk_sys = 0, rst_b = 0, lowRate = 0, calHold = 1, srcValid = 0;
   logic [W-1:0]         srcData = '0;
   logic                 srcReady, txDataValid_q, readStrobe_q, underrun_q;
   logic [W-1:0]         txParallelData_q;
   txos_xcvr_status_type xcvrStatus;
   int                   mismatches = 0, n_compared = 0, cycles = 0;

   // Clock and hang limit
   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         wrap_up();
      end
   end

   // Design and far side
   txos_oversampler uut (.clk_sys(clk_sys), .rst_b(rst_b), .lowRate(lowRate),
      .xcvrStatus(xcvrStatus), .srcValid(srcValid), .srcReady(srcReady), .srcData(srcData),
      .txParallelData_q(txParallelData_q), .txDataValid_q(txDataValid_q),
      .readStrobe_q(readStrobe_q), .underrun_q(underrun_q));
   txos_xcvr_model xcvr (.clk_sys(clk_sys), .rst_b(rst_b), .calHold(calHold),
      .xcvrStatus(xcvrStatus));

   function automatic logic [W-1:0] word(int k);
      return {16'hC3A5 ^ 16'(k), 64'h0123_4567_89AB_CDEF + 64'(k)};
   endfunction

   task automatic check(string what, logic [W-1:0] seen, logic [W-1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("Compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Fill the buffer while the link is held down, then drain it in bypass
   task automatic t_fill_drain();
      int n;
      n = 0;
      srcValid <= 1;
      srcData <= word(0);
      repeat (12) begin
         @(posedge clk_sys);
         if (srcReady === 1'b1) begin
            n++;
            srcData <= word(n);
         end
      end
      srcValid <= 0;
      repeat (2) @(posedge clk_sys);
      check("ready when full", W'(srcReady), '0);
      calHold <= 0;
      n = 0;
      repeat (30) begin
         @(posedge clk_sys);
         if (txDataValid_q === 1'b1) begin
            check("bypass word", txParallelData_q, word(n));
            n++;
         end
      end
      check("bypass count", W'(n), W'(`TXOS_FIFO_DEPTH));
      check("bypass underrun", W'(underrun_q), '0);
      calHold <= 1;
   endtask

   // Two words then an empty buffer through the oversampled path
   task automatic t_oversample();
      logic [W-1:0] got;
      logic         uf;
      int           w;
      uf = 0;
      w = 0;
      repeat (3) @(posedge clk_sys);
      lowRate <= 1;
      for (int k = 0; k < 2; k++) begin
         srcValid <= 1;
         srcData <= word(20 + k);
         do @(posedge clk_sys); while (srcReady !== 1'b1);
      end
      srcValid <= 0;
      calHold <= 0;
      do @(posedge clk_sys); while (readStrobe_q !== 1'b1 && w++ < 30);
      for (int k = 0; k < 3; k++) begin
         for (int c = 0; c < 5; c++) begin
            @(posedge clk_sys);
            for (int j = 0; j < W / 5; j++) got[c*W/5+j] = txParallelData_q[5*j];
            uf |= underrun_q;
         end
         check("strobe spacing", W'(readStrobe_q), W'(1));
         check("oversampled word", got, k < 2 ? word(20 + k) : '0);
         if (k != 1) check("underrun flag", W'(uf), W'(k == 2));
      end
      calHold <= 1;
      repeat (4) @(posedge clk_sys);
      check("valid when down", W'(txDataValid_q), '0);
      lowRate <= 0;
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge clk_sys);
      rst_b <= 1;
      do @(posedge clk_sys); while (srcReady !== 1'b1);
      t_fill_drain();
      t_oversample();
      wrap_up();
   end
endmodule // tb_txos_oversampler

bind txos_oversampler txos_oversampler_checker #(.SYMBOLS(SYMBOLS)) chk (.clk_sys(clk_sys),
   .rst_b(rst_b), .lowRate(lowRate), .xcvrStatus(xcvrStatus),
   .txParallelData_q(txParallelData_q), .txDataValid_q(txDataValid_q),
   .readStrobe_q(readStrobe_q), .underrun_q(underrun_q));
